//--- verification/bcu_decode_model.sv
// Model of the decode and sequencing logic that issues branch requests to the unit.
`timescale 1ns/1ps
`default_nettype none
module bcu_decode_model (
  input wire logic i_mclk,
  input wire logic i_busy,
  input wire logic i_done,
  output logic o_req,
  output bcu_pkg::bcu_op_t o_op,
  output logic [bcu_pkg::BCU_SEL_W-1:0] o_reg_sel,
  output logic [bcu_pkg::BCU_WORD_W-1:0] o_reg_value,
  output bcu_pkg::bcu_ind_t o_ind,
  output logic o_jump_trace
);
  int lat;

  initial begin
    o_req = 1'b0;
    o_op = bcu_pkg::bcu_branch_reg_zero;
    o_reg_sel = 3'h0;
    o_reg_value = 16'h0000;
    o_ind = 4'h0;
    o_jump_trace = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Released operands are inverted so that stale values cannot pass for captured ones.
  task automatic release_ops();
    o_req = 1'b0;
    o_op = bcu_pkg::bcu_op_t'(~o_op);
    o_reg_sel = ~o_reg_sel;
    o_reg_value = ~o_reg_value;
    o_ind = ~o_ind;
    o_jump_trace = ~o_jump_trace;
  endtask

  // Holds a request until taken; with linger it keeps asking while the unit is busy.
  task automatic issue(input bcu_pkg::bcu_op_t op, input logic [2:0] sel, input logic [15:0] v,
                       input bcu_pkg::bcu_ind_t ind, input logic jt, input logic linger);
    logic got;
    @(posedge i_mclk);
    #1;
    o_req = 1'b1;
    o_op = op;
    o_reg_sel = sel;
    o_reg_value = v;
    o_ind = ind;
    o_jump_trace = jt;
    do @(posedge i_mclk); while (i_busy);
    #1;
    if (linger) begin
      o_op = bcu_pkg::bcu_breakpoint_trap;
    end else begin
      release_ops();
    end
    lat = 0;
    got = 1'b0;
    while (!got && lat < 20) begin
      @(posedge i_mclk);
      lat++;
      got = i_done;
      if (lat == 2 && linger) begin
        #1;
        release_ops();
      end
    end
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking testbench for the branch condition unit.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ce = 1'b1;
  logic req, jt, busy, done, cond, wb_en;
  bcu_pkg::bcu_op_t op;
  logic [2:0] sel, wb_sel;
  logic [15:0] val, wb_data;
  bcu_pkg::bcu_ind_t ind;
  bcu_pkg::bcu_result_t res;
  int fail_count = 0;
  int n_compared = 0;
  logic [4:0] ind_ops [8] = '{5'h01, 5'h02, 5'h07, 5'h08, 5'h09, 5'h0b, 5'h0d, 5'h0e};
  logic [4:0] reg_ops [8] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0a, 5'h0c, 5'h0f};
  logic [15:0] vals [8] = '{16'h0000, 16'h0001, 16'h7fff, 16'h8000, 16'hffff, 16'h8001, 16'h0100, 16'hfffe};

  always #2 i_mclk = ~i_mclk;

  bcu_top uut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce), .i_req(req), .i_op(op), .i_reg_sel(sel),
    .i_reg_value(val), .i_ind(ind), .i_jump_trace(jt), .o_busy(busy), .o_done(done), .o_cond_met(cond),
    .o_result(res), .o_wb_en(wb_en), .o_wb_sel(wb_sel), .o_wb_data(wb_data));

  bcu_decode_model partner (.i_mclk(i_mclk), .i_busy(busy), .i_done(done), .o_req(req), .o_op(op),
    .o_reg_sel(sel), .o_reg_value(val), .o_ind(ind), .o_jump_trace(jt));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_res(input string what, input bcu_pkg::bcu_result_t e, input bcu_pkg::bcu_result_t g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic exp_cond(input bcu_pkg::bcu_op_t o, input logic [15:0] v, input bcu_pkg::bcu_ind_t f);
    logic s;
    s = v[bcu_pkg::BCU_SIGN_BIT];
    case (o)
      bcu_pkg::bcu_branch_reg_zero: return v == 16'h0000;
      bcu_pkg::bcu_branch_greater: return f.greater;
      bcu_pkg::bcu_branch_greater_equal: return !f.less;
      bcu_pkg::bcu_branch_reg_nonnegative: return !s;
      bcu_pkg::bcu_branch_reg_positive: return !s && v[14:0] != 15'h0000;
      bcu_pkg::bcu_increment_and_branch: return v != 16'hffff;
      bcu_pkg::bcu_decrement_and_branch: return v != 16'h0000;
      bcu_pkg::bcu_branch_io_false: return !f.io;
      bcu_pkg::bcu_branch_io_true: return f.io;
      bcu_pkg::bcu_branch_less: return f.less;
      bcu_pkg::bcu_branch_reg_nonpositive: return s || v == 16'h0000;
      bcu_pkg::bcu_branch_not_equal: return f.greater || f.less;
      bcu_pkg::bcu_branch_reg_nonzero: return v != 16'h0000;
      bcu_pkg::bcu_branch_no_overflow: return !f.overflow_flag;
      bcu_pkg::bcu_branch_overflow: return f.overflow_flag;
      bcu_pkg::bcu_branch_reg_odd: return v[bcu_pkg::BCU_ODD_BIT];
      default: return 1'b0;
    endcase
  endfunction

  function automatic bcu_pkg::bcu_result_t exp_res(input logic breakpoint_trap, input logic c, input logic t, input logic bad);
    bcu_pkg::bcu_result_t r;
    r = '0;
    r.vector = bcu_pkg::BCU_VEC_NONE;
    if (breakpoint_trap) begin
      r.trap = 1'b1;
      r.vector = bcu_pkg::BCU_VEC_BREAKPOINT;
    end else if (bad) begin
      r.bad_op = 1'b1;
      r.next_seq = 1'b1;
    end else if (c && t) begin
      r.trap = 1'b1;
      r.vector = bcu_pkg::BCU_VEC_JUMP_TRACE;
    end else if (c) begin
      r.taken = 1'b1;
    end else begin
      r.next_seq = 1'b1;
    end
    return r;
  endfunction

  // One branch through the unit, with done, result, cond_met and write-back outputs checked where they apply; busy is not checked.
  task automatic run(input logic [4:0] code, input logic [15:0] v, input logic [3:0] f, input logic t,
                     input logic linger);
    bcu_pkg::bcu_op_t o;
    logic c, bad, ext, inc;
    o = bcu_pkg::bcu_op_t'(code);
    bad = code > 5'h10;
    c = exp_cond(o, v, bcu_pkg::bcu_ind_t'(f));
    inc = o == bcu_pkg::bcu_increment_and_branch;
    ext = !bad && (inc || o == bcu_pkg::bcu_decrement_and_branch);
    partner.issue(o, v[2:0], v, bcu_pkg::bcu_ind_t'(f), t, linger);
    chk_word("latency", 16'h0003, 16'(partner.lat));
    chk_bit("done", 1'b1, done);
    chk_res("result", exp_res(o == bcu_pkg::bcu_breakpoint_trap, c, t, bad), res);
    if (!bad) begin
      chk_bit("cond_met", c, cond);
    end
    chk_bit("wb_en", ext, wb_en);
    if (ext) begin
      chk_word("wb_data", inc ? v + bcu_pkg::BCU_ONE : v - bcu_pkg::BCU_ONE, wb_data);
      chk_word("wb_sel", 16'(v[2:0]), 16'(wb_sel));
    end
    repeat (linger ? 5 : 1) begin
      @(posedge i_mclk);
      chk_bit("done pulse", 1'b0, done);
      chk_bit("wb pulse", 1'b0, wb_en);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_mclk);
    chk_res("reset result", '0, res);
    chk_bit("reset busy", 1'b0, busy);
    chk_bit("reset done", 1'b0, done);
    #1;
    i_resetn = 1'b1;
    $display("test reset ended");
    for (int k = 0; k < 8; k++) begin
      for (int f = 0; f < 16; f++) begin
        run(ind_ops[k], 16'h5a5a, 4'(f), 1'b0, 1'b0);
      end
    end
    $display("test indicators ended");
    for (int k = 0; k < 8; k++) begin
      for (int j = 0; j < 8; j++) begin
        run(reg_ops[k], vals[j], 4'(j), 1'b0, 1'b0);
      end
    end
    $display("test registers ended");
    for (int k = 0; k < 17; k++) begin
      run(5'(k), vals[k % 8], 4'(k), 1'b1, 1'b0);
      run(5'(k), vals[(k + 3) % 8], 4'(k + 5), 1'b1, 1'b0);
    end
    run(5'h10, 16'h0000, 4'h0, 1'b0, 1'b0);
    $display("test jump trace ended");
    run(5'h11, 16'h0000, 4'hf, 1'b1, 1'b0);
    run(5'h1f, 16'hffff, 4'h0, 1'b0, 1'b0);
    run(5'h05, 16'h1234, 4'h0, 1'b0, 1'b1);
    $display("test refusal ended");
    conclude();
  end

  initial begin
    #80000;
    fail_count++;
    $display("watchdog expired");
    conclude();
  end
endmodule
`default_nettype wire

//--- verilog/bcu_cond_eval.sv
// Registered condition evaluator for the branch condition unit.
`timescale 1ns/1ps
`default_nettype none
module bcu_cond_eval (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_load,
  input wire bcu_pkg::bcu_op_t i_op,
  input wire logic [bcu_pkg::BCU_WORD_W-1:0] i_value,
  input wire bcu_pkg::bcu_ind_t i_ind,
  output logic o_cond,
  output logic [bcu_pkg::BCU_WORD_W-1:0] o_data,
  output logic o_wb,
  output logic o_bad
);

  logic next_cond;
  logic [bcu_pkg::BCU_WORD_W-1:0] next_data;
  logic next_wb;
  logic next_bad;

  // Returns one when every bit of the word is clear.
  function automatic logic is_zero(input logic [bcu_pkg::BCU_WORD_W-1:0] v);
    return v == bcu_pkg::BCU_ZERO;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Condition decode.
  always_comb begin
    next_cond = 1'b0;
    next_data = i_value;
    next_wb = 1'b0;
    next_bad = 1'b0;
    case (i_op)
      bcu_pkg::bcu_branch_reg_zero: next_cond = is_zero(i_value);
      bcu_pkg::bcu_branch_greater: next_cond = i_ind.greater;
      bcu_pkg::bcu_branch_greater_equal: next_cond = !i_ind.less;
      bcu_pkg::bcu_branch_reg_nonnegative: next_cond = !i_value[bcu_pkg::BCU_SIGN_BIT];
      bcu_pkg::bcu_branch_reg_positive: begin
        next_cond = !i_value[bcu_pkg::BCU_SIGN_BIT] && !is_zero(i_value & bcu_pkg::BCU_LOW_MASK);
      end
      bcu_pkg::bcu_increment_and_branch: begin
        next_data = i_value + bcu_pkg::BCU_ONE;
        next_wb = 1'b1;
        next_cond = !is_zero(next_data);
      end
      bcu_pkg::bcu_decrement_and_branch: begin
        next_data = i_value - bcu_pkg::BCU_ONE;
        next_wb = 1'b1;
        next_cond = next_data != bcu_pkg::BCU_ALL_ONES;
      end
      bcu_pkg::bcu_branch_io_false: next_cond = !i_ind.io;
      bcu_pkg::bcu_branch_io_true: next_cond = i_ind.io;
      bcu_pkg::bcu_branch_less: next_cond = i_ind.less;
      bcu_pkg::bcu_branch_reg_nonpositive: begin
        next_cond = i_value[bcu_pkg::BCU_SIGN_BIT] || is_zero(i_value);
      end
      bcu_pkg::bcu_branch_not_equal: next_cond = i_ind.greater || i_ind.less;
      bcu_pkg::bcu_branch_reg_nonzero: next_cond = !is_zero(i_value);
      bcu_pkg::bcu_branch_no_overflow: next_cond = !i_ind.overflow_flag;
      bcu_pkg::bcu_branch_overflow: next_cond = i_ind.overflow_flag;
      bcu_pkg::bcu_branch_reg_odd: next_cond = i_value[bcu_pkg::BCU_ODD_BIT];
      bcu_pkg::bcu_breakpoint_trap: next_cond = 1'b0;
      default: next_bad = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result register.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cond <= 1'b0;
      o_data <= bcu_pkg::BCU_ZERO;
      o_wb <= 1'b0;
      o_bad <= 1'b0;
    end else if (i_ce && i_load) begin
      o_cond <= next_cond;
      o_data <= next_data;
      o_wb <= next_wb;
      o_bad <= next_bad;
    end
  end

endmodule
`default_nettype wire

//--- verilog/bcu_pkg.sv
// Shared types and constants for the branch condition unit.
package bcu_pkg;

  localparam int BCU_WORD_W = 16;
  localparam int BCU_SEL_W = 3;
  localparam int BCU_VEC_W = 6;

  // The register's sign bit is our bit 15; its odd bit is our bit 0.
  localparam int BCU_SIGN_BIT = 15;
  localparam int BCU_ODD_BIT = 0;

  localparam logic [BCU_WORD_W-1:0] BCU_ZERO = 16'h0000;
  localparam logic [BCU_WORD_W-1:0] BCU_ONE = 16'h0001;
  localparam logic [BCU_WORD_W-1:0] BCU_ALL_ONES = 16'hffff;
  localparam logic [BCU_WORD_W-1:0] BCU_LOW_MASK = 16'h7fff;

  localparam logic [BCU_VEC_W-1:0] BCU_VEC_NONE = 6'h00;
  localparam logic [BCU_VEC_W-1:0] BCU_VEC_JUMP_TRACE = 6'h02;
  localparam logic [BCU_VEC_W-1:0] BCU_VEC_BREAKPOINT = 6'h02;

  typedef enum logic [4:0] {
    bcu_branch_reg_zero = 5'h00,
    bcu_branch_greater = 5'h01,
    bcu_branch_greater_equal = 5'h02,
    bcu_branch_reg_nonnegative = 5'h03,
    bcu_branch_reg_positive = 5'h04,
    bcu_increment_and_branch = 5'h05,
    bcu_decrement_and_branch = 5'h06,
    bcu_branch_io_false = 5'h07,
    bcu_branch_io_true = 5'h08,
    bcu_branch_less = 5'h09,
    bcu_branch_reg_nonpositive = 5'h0a,
    bcu_branch_not_equal = 5'h0b,
    bcu_branch_reg_nonzero = 5'h0c,
    bcu_branch_no_overflow = 5'h0d,
    bcu_branch_overflow = 5'h0e,
    bcu_branch_reg_odd = 5'h0f,
    bcu_breakpoint_trap = 5'h10
  } bcu_op_t;

  typedef enum logic [1:0] {
    bcu_st_idle = 2'b00,
    bcu_st_eval = 2'b01,
    bcu_st_resp = 2'b10
  } bcu_state_t;

  typedef struct packed {
    logic greater;
    logic less;
    logic io;
    logic overflow_flag;
  } bcu_ind_t;

  typedef struct packed {
    logic taken;
    logic trap;
    logic next_seq;
    logic bad_op;
    logic [BCU_VEC_W-1:0] vector;
  } bcu_result_t;

endpackage

//--- verilog/bcu_top.sv
// Branch condition unit: takes a branch request, decides branch, trap or fall through.
`timescale 1ns/1ps
`default_nettype none
module bcu_top (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_req,
  input wire bcu_pkg::bcu_op_t i_op,
  input wire logic [bcu_pkg::BCU_SEL_W-1:0] i_reg_sel,
  input wire logic [bcu_pkg::BCU_WORD_W-1:0] i_reg_value,
  input wire bcu_pkg::bcu_ind_t i_ind,
  input wire logic i_jump_trace,
  output logic o_busy,
  output logic o_done,
  output logic o_cond_met,
  output bcu_pkg::bcu_result_t o_result,
  output logic o_wb_en,
  output logic [bcu_pkg::BCU_SEL_W-1:0] o_wb_sel,
  output logic [bcu_pkg::BCU_WORD_W-1:0] o_wb_data
);

  bcu_pkg::bcu_state_t state;
  bcu_pkg::bcu_op_t cap_op;
  logic [bcu_pkg::BCU_SEL_W-1:0] cap_sel;
  logic [bcu_pkg::BCU_WORD_W-1:0] cap_value;
  bcu_pkg::bcu_ind_t cap_ind;
  logic cap_jt;
  logic accept;
  logic ev_cond;
  logic [bcu_pkg::BCU_WORD_W-1:0] ev_data;
  logic ev_wb;
  logic ev_bad;
  bcu_pkg::bcu_result_t next_result;

  assign accept = i_req && (state == bcu_pkg::bcu_st_idle);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: idle, evaluate, respond.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= bcu_pkg::bcu_st_idle;
    end else if (i_ce) begin
      case (state)
        bcu_pkg::bcu_st_idle: begin
          if (i_req) begin
            state <= bcu_pkg::bcu_st_eval;
          end
        end
        bcu_pkg::bcu_st_eval: state <= bcu_pkg::bcu_st_resp;
        bcu_pkg::bcu_st_resp: state <= bcu_pkg::bcu_st_idle;
        default: state <= bcu_pkg::bcu_st_idle;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_busy <= 1'b0;
    end else if (i_ce) begin
      if (accept) begin
        o_busy <= 1'b1;
      end else if (state == bcu_pkg::bcu_st_resp) begin
        o_busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Operand capture; the indicators are a read-only snapshot.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cap_op <= bcu_pkg::bcu_branch_reg_zero;
      cap_sel <= '0;
      cap_value <= bcu_pkg::BCU_ZERO;
      cap_ind <= '0;
      cap_jt <= 1'b0;
    end else if (i_ce && accept) begin
      cap_op <= i_op;
      cap_sel <= i_reg_sel;
      cap_value <= i_reg_value;
      cap_ind <= i_ind;
      cap_jt <= i_jump_trace;
    end
  end

  bcu_cond_eval u_eval (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_load(state == bcu_pkg::bcu_st_eval),
    .i_op(cap_op),
    .i_value(cap_value),
    .i_ind(cap_ind),
    .o_cond(ev_cond),
    .o_data(ev_data),
    .o_wb(ev_wb),
    .o_bad(ev_bad)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Outcome selection: breakpoint, bad code, trace trap, taken or fall through.
  always_comb begin
    next_result = '0;
    next_result.vector = bcu_pkg::BCU_VEC_NONE;
    if (cap_op == bcu_pkg::bcu_breakpoint_trap) begin
      next_result.trap = 1'b1;
      next_result.vector = bcu_pkg::BCU_VEC_BREAKPOINT;
    end else if (ev_bad) begin
      next_result.bad_op = 1'b1;
      next_result.next_seq = 1'b1;
    end else if (ev_cond && cap_jt) begin
      next_result.trap = 1'b1;
      next_result.vector = bcu_pkg::BCU_VEC_JUMP_TRACE;
    end else if (ev_cond) begin
      next_result.taken = 1'b1;
    end else begin
      next_result.next_seq = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_result <= '0;
      o_cond_met <= 1'b0;
    end else if (i_ce && state == bcu_pkg::bcu_st_resp) begin
      o_result <= next_result;
      o_cond_met <= ev_cond;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= (state == bcu_pkg::bcu_st_resp);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register write-back for increment and decrement, also when a trace trap follows.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_en <= 1'b0;
      o_wb_sel <= '0;
      o_wb_data <= bcu_pkg::BCU_ZERO;
    end else if (i_ce) begin
      o_wb_en <= (state == bcu_pkg::bcu_st_resp) && ev_wb;
      if (state == bcu_pkg::bcu_st_resp && ev_wb) begin
        o_wb_sel <= cap_sel;
        o_wb_data <= ev_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  a_done_latency: assert property ($rose(o_busy) ##0 i_ce ##1 i_ce |=> o_done && !o_busy)
    else $error("done not two enabled cycles after accept");
  a_reg_zero: assert property (o_done && cap_op == bcu_pkg::bcu_branch_reg_zero
      |-> o_cond_met == (cap_value == bcu_pkg::BCU_ZERO))
    else $error("register zero branch wrong");
  a_jump_trace: assert property (o_done && o_cond_met && cap_jt
      |-> o_result.trap && !o_result.taken && o_result.vector == bcu_pkg::BCU_VEC_JUMP_TRACE)
    else $error("jump trace trap missing");
  a_trace_off_taken: assert property (o_done && o_cond_met && !cap_jt && !o_result.bad_op
      |-> o_result.taken && !o_result.trap)
    else $error("met branch not taken");
  a_greater_ind: assert property (o_done && cap_op == bcu_pkg::bcu_branch_greater
      |-> o_cond_met == cap_ind.greater)
    else $error("greater branch wrong");
  a_greater_equal: assert property (o_done && cap_op == bcu_pkg::bcu_branch_greater_equal
      |-> o_cond_met == !cap_ind.less)
    else $error("greater or equal branch wrong");
  a_reg_nonneg: assert property (o_done && cap_op == bcu_pkg::bcu_branch_reg_nonnegative
      |-> o_cond_met == !cap_value[bcu_pkg::BCU_SIGN_BIT])
    else $error("nonnegative branch wrong");
  a_reg_positive: assert property (o_done && cap_op == bcu_pkg::bcu_branch_reg_positive
      |-> o_cond_met == (!cap_value[bcu_pkg::BCU_SIGN_BIT] && cap_value != bcu_pkg::BCU_ZERO))
    else $error("positive branch wrong");
  a_increment_wb: assert property (o_done && cap_op == bcu_pkg::bcu_increment_and_branch
      |-> o_wb_en && o_wb_sel == cap_sel && o_wb_data == 16'(cap_value + bcu_pkg::BCU_ONE)
      && o_cond_met == (cap_value != bcu_pkg::BCU_ALL_ONES))
    else $error("increment and branch wrong");
  a_io_false: assert property (o_done && cap_op == bcu_pkg::bcu_branch_io_false
      |-> o_cond_met == !cap_ind.io)
    else $error("io false branch wrong");
  a_io_true: assert property (o_done && cap_op == bcu_pkg::bcu_branch_io_true
      |-> o_cond_met == cap_ind.io)
    else $error("io true branch wrong");
  a_less_ind: assert property (o_done && cap_op == bcu_pkg::bcu_branch_less
      |-> o_cond_met == cap_ind.less)
    else $error("less branch wrong");
  a_reg_nonpos: assert property (o_done && cap_op == bcu_pkg::bcu_branch_reg_nonpositive
      |-> o_cond_met == (cap_value[bcu_pkg::BCU_SIGN_BIT] || cap_value == bcu_pkg::BCU_ZERO))
    else $error("nonpositive branch wrong");
  a_not_equal: assert property (o_done && cap_op == bcu_pkg::bcu_branch_not_equal
      |-> o_cond_met == (cap_ind.greater || cap_ind.less))
    else $error("not equal branch wrong");
  a_reg_nonzero: assert property (o_done && cap_op == bcu_pkg::bcu_branch_reg_nonzero
      |-> o_cond_met == (cap_value != bcu_pkg::BCU_ZERO))
    else $error("nonzero branch wrong");
  a_no_overflow: assert property (o_done && cap_op == bcu_pkg::bcu_branch_no_overflow
      |-> o_cond_met == !cap_ind.overflow_flag)
    else $error("no overflow branch wrong");
  a_overflow_ind: assert property (o_done && cap_op == bcu_pkg::bcu_branch_overflow
      |-> o_cond_met == cap_ind.overflow_flag)
    else $error("overflow branch wrong");
  a_reg_odd: assert property (o_done && cap_op == bcu_pkg::bcu_branch_reg_odd
      |-> o_cond_met == cap_value[bcu_pkg::BCU_ODD_BIT])
    else $error("odd branch wrong");
  a_breakpoint_trap: assert property (o_done && cap_op == bcu_pkg::bcu_breakpoint_trap
      |-> o_result.trap && o_result.vector == bcu_pkg::BCU_VEC_BREAKPOINT && !o_result.taken)
    else $error("breakpoint did not trap");
  a_decrement_wb: assert property (o_done && cap_op == bcu_pkg::bcu_decrement_and_branch
      |-> o_wb_en && o_wb_data == 16'(cap_value - bcu_pkg::BCU_ONE)
      && o_cond_met == (cap_value != bcu_pkg::BCU_ZERO))
    else $error("decrement and branch wrong");
  a_not_met_seq: assert property (o_done && !o_cond_met && cap_op != bcu_pkg::bcu_breakpoint_trap
      |-> o_result.next_seq && !o_result.trap && !o_result.taken)
    else $error("unmet branch did not fall through");
  a_ind_snapshot: assert property (o_busy |=> $stable(cap_ind) && $stable(cap_value))
    else $error("snapshot changed while busy");

endmodule
`default_nettype wire
